// [rtl/rac_cmd_handler.v]
// Purpose: Relay, polarity and temperature alarm command handler.
// Assumes: Byte stream from a receiver on the same clock; replies
//   leave through a valid/ready byte port; pins pass 2 flops.
// Notes: Half duplex: characters arriving while a reply is being
//   sent are dropped.
// Notes on behaviour
// - A relay state field of 00 turns the relay off, 01 turns it on.
// - Accepted commands answer with ! and the address, rejected with ?.
// - Bad syntax, a link error or a foreign address gives no reply.
// - Addresses are two upper-case hex characters, 00 to FF.
// - A manual relay command is rejected while the relay follows motion.
// - A relay linked to motion is active whenever the trigger is high.
// - With the link off, manual relay commands are obeyed.
// - The polarity read returns two hex digits with only bit 1 used.
// - Polarity 0 drives 1 for active; polarity 1 drives 0 for active.
// - Polarity writes store the value; any bit but bit 1 is rejected.
// - The arm command enables the alarm, M momentary or L latched.
// - The disable command turns the alarm off and is acknowledged.
// - The clear command drops a latched alarm and is acknowledged.
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "rac_defines.vh"

module rac_cmd_handler #(
  parameter BODY_MAX = `RAC_BODY_MAX
) (
  input wire clock,
  input wire sys_rst,
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire rx_err,
  output wire [7:0] tx_data,
  output wire tx_valid,
  input wire tx_ready,
  input wire pir_trig,
  input wire over_temp,
  output wire relay_out,
  output wire alarm_out,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [31:0] reg_rdata,
  output wire irq
);

  // --------------------------------------------------------
  // States
  // --------------------------------------------------------
  localparam [3:0] ST_HUNT = 4'b0001;
  localparam [3:0] ST_RECV = 4'b0010;
  localparam [3:0] ST_PARSE = 4'b0100;
  localparam [3:0] ST_SEND = 4'b1000;

  // --------------------------------------------------------
  // Helpers
  // --------------------------------------------------------
  // Returns {valid, value}; lower-case digits are not hex here
  function [4:0] hex_val;
    input [7:0] c;
    begin
      if (c >= 8'h30 && c <= 8'h39)
        hex_val = {1'b1, c[3:0]};
      else if (c >= 8'h41 && c <= 8'h46)
        hex_val = {1'b1, c[3:0] + 4'h9};
      else
        hex_val = 5'h00;
    end
  endfunction

  function [7:0] hex_char;
    input [3:0] n;
    begin
      if (n < 4'hA)
        hex_char = {4'h3, n};
      else
        hex_char = {4'h4, n - 4'h9};
    end
  endfunction

  // --------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------
  reg [1:0] pir_sync_ff;
  reg [1:0] temp_sync_ff;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pir_sync_ff <= 2'h0;
      temp_sync_ff <= 2'h0;
    end else begin
      pir_sync_ff <= {pir_sync_ff[0], pir_trig};
      temp_sync_ff <= {temp_sync_ff[0], over_temp};
    end
  end
  wire pir_s = pir_sync_ff[1];
  wire hot_s = temp_sync_ff[1];

  // --------------------------------------------------------
  // Frame receiver
  // --------------------------------------------------------
  reg [3:0] state_ff;
  reg [7:0] body_ff [0:BODY_MAX-1];
  reg [3:0] len_ff;
  reg tilde_ff;
  reg bad_ff;
  integer i, j;

  wire is_delim = (rx_data == `RAC_CH_AT) || (rx_data == `RAC_CH_TILDE);
  wire is_cr = (rx_data == `RAC_CH_CR);

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (i = 0; i < BODY_MAX; i = i + 1)
        body_ff[i] <= 8'h00;
      len_ff <= 4'h0;
      tilde_ff <= 1'b0;
      bad_ff <= 1'b0;
    end else if (rx_valid && (state_ff == ST_HUNT ||
                 state_ff == ST_RECV)) begin
      if (is_delim) begin
        // A new delimiter restarts the frame
        len_ff <= 4'h0;
        tilde_ff <= (rx_data == `RAC_CH_TILDE);
        bad_ff <= rx_err;
      end else if (state_ff == ST_RECV && !is_cr) begin
        if (len_ff < BODY_MAX) begin
          body_ff[len_ff[2:0]] <= rx_data;
          len_ff <= len_ff + 4'h1;
        end else begin
          bad_ff <= 1'b1;
        end
        if (rx_err)
          bad_ff <= 1'b1;
      end else if (rx_err) begin
        bad_ff <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------
  // Command decode (combinational, read in ST_PARSE, one cycle after CR)
  // --------------------------------------------------------
  reg [7:0] module_addr_ff;
  reg link_ff;
  reg relay_man_ff;
  reg [7:0] pol_val_ff;
  reg alarm_en_ff;
  reg latch_mode_ff;
  reg latched_ff;

  wire [4:0] a_hi = hex_val(body_ff[0]);
  wire [4:0] a_lo = hex_val(body_ff[1]);
  wire [4:0] f_hi = hex_val(body_ff[3]);
  wire [4:0] f_lo = hex_val(body_ff[4]);
  wire [4:0] g_hi = hex_val(body_ff[4]);
  wire [4:0] g_lo = hex_val(body_ff[5]);
  wire [7:0] relay_state_field = {g_hi[3:0], g_lo[3:0]};
  wire [7:0] polarity_value_field = {f_hi[3:0], f_lo[3:0]};
  wire addr_ok = a_hi[4] && a_lo[4];
  wire addr_hit = ({a_hi[3:0], a_lo[3:0]} == module_addr_ff);
  wire c2d = (body_ff[2] == `RAC_CH_D);

  wire is_relay = !tilde_ff && len_ff == `RAC_LEN_RELAY && c2d &&
    body_ff[3] == `RAC_CH_O && g_hi[4] && g_lo[4];
  wire is_pol_rd = tilde_ff && len_ff == `RAC_LEN_POL_RD && c2d;
  wire is_pol_wr = tilde_ff && len_ff == `RAC_LEN_POL_WR && c2d &&
    f_hi[4] && f_lo[4];
  wire latch_alarm_clear_cmd = !tilde_ff && len_ff == `RAC_LEN_CLR &&
    body_ff[2] == `RAC_CH_C && body_ff[3] == `RAC_CH_H &&
    body_ff[4] == `RAC_CH_C && body_ff[5] == `RAC_CH_0;
  wire alarm_disable_cmd = !tilde_ff && len_ff == `RAC_LEN_DIS &&
    c2d && body_ff[3] == `RAC_CH_A;
  wire alarm_arm_cmd = !tilde_ff && len_ff == `RAC_LEN_ARM &&
    body_ff[2] == `RAC_CH_E && body_ff[3] == `RAC_CH_A;

  wire known = is_relay || is_pol_rd || is_pol_wr ||
    latch_alarm_clear_cmd || alarm_disable_cmd || alarm_arm_cmd;
  wire answer = known && addr_ok && addr_hit && !bad_ff;

  wire arm_m = (body_ff[4] == `RAC_CH_M);
  wire arm_l = (body_ff[4] == `RAC_CH_L);
  wire reject = (is_relay && (link_ff || relay_state_field > 8'h01))
    || (is_pol_wr && |(polarity_value_field & `RAC_POL_MASK))
    || (alarm_arm_cmd && !arm_m && !arm_l);
  wire accept = answer && !reject;

  // --------------------------------------------------------
  // Reply assembly and sequencing
  // --------------------------------------------------------
  reg [7:0] rep_ff [0:5];
  reg [2:0] rep_len_ff;
  reg [2:0] tx_idx_ff;
  reg [7:0] tx_data_ff;
  reg tx_valid_ff;
  reg [3:0] nxt_state;

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_HUNT: begin
        if (rx_valid && is_delim)
          nxt_state = ST_RECV;
      end
      ST_RECV: begin
        if (rx_valid && is_cr)
          nxt_state = ST_PARSE;
      end
      ST_PARSE: begin
        nxt_state = answer ? ST_SEND : ST_HUNT;
      end
      ST_SEND: begin
        if (tx_valid_ff && tx_ready && tx_idx_ff == rep_len_ff)
          nxt_state = ST_HUNT;
      end
      default: nxt_state = ST_HUNT;
    endcase
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_HUNT;
      for (j = 0; j < 6; j = j + 1)
        rep_ff[j] <= 8'h00;
      rep_len_ff <= 3'h0;
      tx_idx_ff <= 3'h0;
      tx_data_ff <= 8'h00;
      tx_valid_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_PARSE && answer) begin
        rep_ff[0] <= accept ? `RAC_CH_OK : `RAC_CH_BAD;
        rep_ff[1] <= body_ff[0];
        rep_ff[2] <= body_ff[1];
        tx_idx_ff <= 3'h0;
        if (accept && is_pol_rd) begin
          rep_ff[3] <= hex_char(pol_val_ff[7:4]);
          rep_ff[4] <= hex_char(pol_val_ff[3:0]);
          rep_ff[5] <= `RAC_CH_CR;
          rep_len_ff <= `RAC_REP_LONG;
        end else begin
          rep_ff[3] <= `RAC_CH_CR;
          rep_len_ff <= `RAC_REP_SHORT;
        end
      end else if (state_ff == ST_SEND) begin
        if (!tx_valid_ff) begin
          tx_data_ff <= rep_ff[tx_idx_ff];
          tx_valid_ff <= 1'b1;
          tx_idx_ff <= tx_idx_ff + 3'h1;
        end else if (tx_ready) begin
          tx_valid_ff <= 1'b0;
        end
      end
    end
  end

  assign tx_data = tx_data_ff;
  assign tx_valid = tx_valid_ff;

  // --------------------------------------------------------
  // Stored settings
  // --------------------------------------------------------
  wire do_cmd = (state_ff == ST_PARSE) && accept;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      relay_man_ff <= 1'b0;
      pol_val_ff <= 8'h00;
      alarm_en_ff <= 1'b0;
      latch_mode_ff <= 1'b0;
      latched_ff <= 1'b0;
    end else begin
      if (do_cmd && is_relay)
        relay_man_ff <= relay_state_field[0];
      if (do_cmd && is_pol_wr)
        pol_val_ff <= polarity_value_field;
      if (do_cmd && alarm_arm_cmd) begin
        alarm_en_ff <= 1'b1;
        latch_mode_ff <= arm_l;
      end
      if (do_cmd && alarm_disable_cmd)
        alarm_en_ff <= 1'b0;
      // Condition still present re-latches over a clear
      if (alarm_en_ff && latch_mode_ff && hot_s)
        latched_ff <= 1'b1;
      else if (do_cmd && (latch_alarm_clear_cmd || alarm_disable_cmd))
        latched_ff <= 1'b0;
    end
  end

  // --------------------------------------------------------
  // Outputs to the plant
  // --------------------------------------------------------
  wire polarity_select_bit = pol_val_ff[`RAC_POL_BIT];
  wire relay_active = link_ff ? pir_s : relay_man_ff;
  wire alarm_active = alarm_en_ff &&
    (latch_mode_ff ? (latched_ff || hot_s) : hot_s);
  reg relay_out_ff;
  reg alarm_out_ff;
  reg alarm_d_ff;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      relay_out_ff <= 1'b0;
      alarm_out_ff <= 1'b0;
      alarm_d_ff <= 1'b0;
    end else begin
      relay_out_ff <= relay_active ^ polarity_select_bit;
      alarm_out_ff <= alarm_active;
      alarm_d_ff <= alarm_active;
    end
  end

  assign relay_out = relay_out_ff;
  assign alarm_out = alarm_out_ff;

  // --------------------------------------------------------
  // Register port and interrupts
  // --------------------------------------------------------
  reg [2:0] status_ff;
  reg [2:0] irq_en_ff;
  reg [31:0] rdata_ff;
  wire [2:0] events;

  assign events[`RAC_EV_ACCEPT] = do_cmd;
  assign events[`RAC_EV_REJECT] = (state_ff == ST_PARSE) && answer &&
    reject;
  assign events[`RAC_EV_ALARM] = alarm_active && !alarm_d_ff;

  wire clr_hit = reg_wr && reg_addr == `RAC_OFS_IRQ_CLR;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      module_addr_ff <= `RAC_ADDR_RST;
      link_ff <= `RAC_LINK_RST;
      status_ff <= 3'h0;
      irq_en_ff <= 3'h0;
      rdata_ff <= 32'h00000000;
    end else begin
      if (reg_wr && reg_addr == `RAC_OFS_CTRL) begin
        module_addr_ff <= reg_wdata[7:0];
        link_ff <= reg_wdata[`RAC_CTRL_LINK_BIT];
      end
      if (reg_wr && reg_addr == `RAC_OFS_IRQ_EN)
        irq_en_ff <= reg_wdata[2:0];
      // A new event wins over a clear in the same cycle
      status_ff <= (status_ff & ~(clr_hit ? reg_wdata[2:0] : 3'h0))
        | events;
      rdata_ff <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `RAC_OFS_CTRL:
            rdata_ff <= {23'h000000, link_ff, module_addr_ff};
          `RAC_OFS_STATE:
            rdata_ff <= {24'h000000, pol_val_ff[7:2], relay_active,
                         alarm_active} | {19'h00000, latched_ff,
                         latch_mode_ff, alarm_en_ff, 10'h000};
          `RAC_OFS_STATUS: rdata_ff <= {29'h00000000, status_ff};
          `RAC_OFS_IRQ_EN: rdata_ff <= {29'h00000000, irq_en_ff};
          default: rdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq = |(status_ff & irq_en_ff);

endmodule

// [rtl/rac_defines.vh]
// Purpose: Constants for the relay and alarm command handler.
// Assumes: Included by bare name from rtl/.
// Notes: Definitions only.
`ifndef RAC_DEFINES_VH
`define RAC_DEFINES_VH

// ----------------------------------------------------------
// Register offsets
// ----------------------------------------------------------
`define RAC_OFS_CTRL 8'h00
`define RAC_OFS_STATE 8'h04
`define RAC_OFS_STATUS 8'h08
`define RAC_OFS_IRQ_EN 8'h0C
`define RAC_OFS_IRQ_CLR 8'h10

// ----------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------
`define RAC_CTRL_LINK_BIT 8
`define RAC_ADDR_RST 8'h01
`define RAC_LINK_RST 1'b1
`define RAC_EV_ACCEPT 0
`define RAC_EV_REJECT 1
`define RAC_EV_ALARM 2
`define RAC_POL_BIT 1
`define RAC_POL_MASK 8'hFD

// ----------------------------------------------------------
// Characters
// ----------------------------------------------------------
`define RAC_CH_AT 8'h40
`define RAC_CH_TILDE 8'h7E
`define RAC_CH_CR 8'h0D
`define RAC_CH_OK 8'h21
`define RAC_CH_BAD 8'h3F
`define RAC_CH_D 8'h44
`define RAC_CH_O 8'h4F
`define RAC_CH_C 8'h43
`define RAC_CH_H 8'h48
`define RAC_CH_0 8'h30
`define RAC_CH_A 8'h41
`define RAC_CH_E 8'h45
`define RAC_CH_M 8'h4D
`define RAC_CH_L 8'h4C

// ----------------------------------------------------------
// Frame lengths (characters after the delimiter, before CR) and reply lengths (all characters, CR included)
// ----------------------------------------------------------
`define RAC_BODY_MAX 8
`define RAC_LEN_RELAY 4'd6
`define RAC_LEN_POL_RD 4'd3
`define RAC_LEN_POL_WR 4'd5
`define RAC_LEN_CLR 4'd6
`define RAC_LEN_DIS 4'd4
`define RAC_LEN_ARM 4'd5
`define RAC_REP_SHORT 3'd4
`define RAC_REP_LONG 3'd6

`endif

// [testbench/rac_cmd_asserts.sv]
// Purpose: Port checks for the relay and alarm command handler.
// Assumes: Module address changes only while no reply is under way.
// Notes: Reply position is followed from the link handshakes.
`timescale 1ns/100ps
module rac_cmd_asserts (
  input wire clock,
  input wire sys_rst,
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire rx_err,
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire tx_ready,
  input wire over_temp,
  input wire alarm_out,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr
);
  // ----------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------
  reg [2:0] pos_ff;
  reg [7:0] addr_ff;
  reg err_ff;
  wire hs = tx_valid && tx_ready;
  wire dlm = (rx_data == 8'h40) || (rx_data == 8'h7E);
  function [7:0] hx(input [3:0] n);
    hx = (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pos_ff <= 3'h0;
      addr_ff <= 8'h01;
      err_ff <= 1'b0;
    end else begin
      if (hs)
        pos_ff <= (tx_data == 8'h0D) ? 3'h0 : pos_ff + 3'h1;
      if (reg_wr && reg_addr == 8'h00)
        addr_ff <= reg_wdata[7:0];
      // A delimiter restarts the frame and forgets older errors
      if (rx_valid)
        err_ff <= dlm ? rx_err : (err_ff | rx_err);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  tx_hold_a: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply character dropped before handshake");
  tx_gap_a: assert property (hs |=> !tx_valid)
    else $error("no idle cycle after a reply character");
  reply_delim_a: assert property (
    tx_valid && pos_ff == 3'h0 |-> tx_data == 8'h21 || tx_data == 8'h3F)
    else $error("reply does not open with a delimiter");
  addr_hi_a: assert property (
    tx_valid && pos_ff == 3'h1 |-> tx_data == hx(addr_ff[7:4]))
    else $error("reply address high digit wrong");
  addr_lo_a: assert property (
    tx_valid && pos_ff == 3'h2 |-> tx_data == hx(addr_ff[3:0]))
    else $error("reply address low digit wrong");
  reply_start_a: assert property (
    $rose(tx_valid) && pos_ff == 3'h0 |->
      $past(rx_valid, 3) && $past(rx_data, 3) == 8'h0D)
    else $error("reply not started three edges after CR");
  reply_chars_a: assert property (
    tx_valid |-> tx_data inside {8'h21, 8'h3F, 8'h0D, [8'h30:8'h39],
                                 [8'h41:8'h46]})
    else $error("reply holds a character that is not upper hex");
  err_silent_a: assert property (
    rx_valid && rx_data == 8'h0D && (err_ff || rx_err) && !tx_valid
      |=> (!tx_valid) [*5])
    else $error("reply sent for a spoiled frame");
  alarm_cause_a: assert property (
    $rose(alarm_out) |-> $past(over_temp, 3))
    else $error("alarm rose without the over-temperature input");
endmodule

bind rac_cmd_handler rac_cmd_asserts u_chk (.clock(clock),
  .sys_rst(sys_rst), .rx_data(rx_data), .rx_valid(rx_valid),
  .rx_err(rx_err), .tx_data(tx_data), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .over_temp(over_temp), .alarm_out(alarm_out),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr));

// [testbench/rac_host_model.sv]
// Purpose: Host side of the command link: sends frames, sinks replies.
// Assumes: One frame in flight; the bench waits for each reply.
// Notes: The idle data line shows the inverse of the last character.
`timescale 1ns/100ps
module rac_host_model (
  input wire clock,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_err,
  input wire [7:0] tx_data,
  input wire tx_valid,
  output logic tx_ready
);
  // ----------------------------------------------------------
  // Sender and stalling sink
  // ----------------------------------------------------------
  logic [7:0] rep[$];
  logic slow = 1'b0;
  logic [7:0] lf = 8'h5A;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_err = 1'b0;
    tx_ready = 1'b1;
  end
  always @(posedge clock) begin
    if (tx_valid && tx_ready)
      rep.push_back(tx_data);
    lf <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    tx_ready <= !slow || lf[0];
  end
  // The bad index marks the character carrying a line error
  task automatic send(input string s, input int bad);
    for (int i = 0; i <= s.len(); i++) begin
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_data <= (i == s.len()) ? 8'h0D : s[i];
      rx_err <= (i == bad);
    end
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_err <= 1'b0;
    rx_data <= ~rx_data;
  endtask
endmodule

// [testbench/test_relay_alarm_cmd_handler.sv]
// Purpose: Self-checking bench for the relay and alarm command handler.
// Assumes: Replies finish well inside the wait bound.
// Notes: Random addresses and sink stalls come from a fixed seed.
`timescale 1ns/100ps
module test_relay_alarm_cmd_handler;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic pir_trig = 1'b0, over_temp = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] seed = 32'hED041FFC;
  wire [7:0] rx_data, tx_data;
  wire rx_valid, rx_err, tx_valid, tx_ready, relay_out, alarm_out, irq;
  wire [31:0] reg_rdata;
  int num_errors = 0, n_checks = 0;
  always #4 clock = ~clock;
  rac_cmd_handler dut (.clock(clock), .sys_rst(sys_rst),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_err(rx_err),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .pir_trig(pir_trig), .over_temp(over_temp), .relay_out(relay_out),
    .alarm_out(alarm_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  rac_host_model host (.clock(clock), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_err(rx_err), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready));
  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic string h2(input logic [7:0] v);
    string s = "00";
    s[0] = (v[7:4] < 4'hA) ? 8'h30 + v[7:4] : 8'h37 + v[7:4];
    s[1] = (v[3:0] < 4'hA) ? 8'h30 + v[3:0] : 8'h37 + v[3:0];
    return s;
  endfunction
  task automatic final_report;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic settle;
    repeat (5) @(posedge clock);
    #1;
  endtask
  // Pins move on a clock edge; the design's two flops take it from there
  task automatic pins(input logic p, input logic t);
    @(posedge clock);
    pir_trig <= p;
    over_temp <= t;
  endtask
  // An empty expectation means the frame must stay unanswered
  task automatic cmd(input string s, input string exp, input int bad = -1);
    int n, lim;
    lim = (exp == "") ? 40 : 400;
    host.rep.delete();
    host.send(s, bad);
    for (n = 0; n < lim; n++) begin
      if (host.rep.size() > 0 && host.rep[$] === 8'h0D)
        break;
      @(posedge clock);
    end
    if (exp != "" && n == lim) begin
      chk(0, 1);
      final_report();
    end else begin
      if (exp == "") begin
        chk(host.rep.size(), 0);
      end else begin
        chk(host.rep.size(), exp.len() + 1);
        for (int i = 0; i < exp.len(); i++)
          chk(host.rep[i], exp[i]);
      end
      settle();
    end
  endtask
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    logic [7:0] a;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    #1 chk({tx_valid, relay_out, alarm_out, irq}, 4'h0);
    rdc(8'h00, 32'h101);
    rdc(8'h20, 32'h0);
    cmd("@01DO01", "?01");
    chk(relay_out, 1'b0);
    pins(1'b1, 1'b0);
    settle();
    chk(relay_out, 1'b1);
    pins(1'b0, 1'b0);
    wr(8'h00, 32'h001);
    cmd("@01DO01", "!01");
    chk(relay_out, 1'b1);
    cmd("@01DO02", "?01");
    chk(relay_out, 1'b1);
    cmd("@01DO00", "!01");
    chk(relay_out, 1'b0);
    cmd("~01D02", "!01");
    chk(relay_out, 1'b1);
    cmd("~01D", "!0102");
    cmd("~01D07", "?01");
    cmd("~01D", "!0102");
    cmd("~01D00", "!01");
    chk(relay_out, 1'b0);
    wr(8'h10, 32'h7);
    wr(8'h0C, 32'h2);
    cmd("@01DA", "!01");
    chk(irq, 1'b0);
    cmd("@01EAX", "?01");
    chk(irq, 1'b1);
    rdc(8'h08, 32'h3);
    wr(8'h0C, 32'h0);
    chk(irq, 1'b0);
    wr(8'h0C, 32'h2);
    chk(irq, 1'b1);
    rdc(8'h0C, 32'h2);
    wr(8'h10, 32'h2);
    chk(irq, 1'b0);
    cmd("@01EAM", "!01");
    pins(1'b0, 1'b1);
    settle();
    chk(alarm_out, 1'b1);
    rdc(8'h08, 32'h5);
    pins(1'b0, 1'b0);
    settle();
    chk(alarm_out, 1'b0);
    cmd("@01EAL", "!01");
    pins(1'b0, 1'b1);
    settle();
    pins(1'b0, 1'b0);
    settle();
    chk(alarm_out, 1'b1);
    rdc(8'h04, 32'h1C01);
    cmd("@01CHC0", "!01");
    chk(alarm_out, 1'b0);
    cmd("@01DA", "!01");
    pins(1'b0, 1'b1);
    settle();
    chk(alarm_out, 1'b0);
    pins(1'b0, 1'b0);
    cmd("@02DA", "");
    cmd("@01da", "");
    cmd("@01DA", "", 2);
    // Corner addresses first, then random ones; a coin flip per frame picks a stalling sink
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'(xs());
      host.slow <= (xs() & 32'h1) != 32'h0;
      wr(8'h00, {24'h0, a});
      cmd({"@", h2(a), "DA"}, {"!", h2(a)});
    end
    final_report();
  end
endmodule
